// >>> logic/sleep_wake_pkg.sv
package sleep_wake_pkg;

   // Register byte addresses on the AXI4-Lite slave
   localparam logic [7:0]  OPTION_ADDR      = 8'h00;
   localparam logic [7:0]  STATUS_ADDR      = 8'h04;

   // Values after reset
   localparam logic [7:0]  OPTION_RESET     = 8'hff;

   // Bit positions of the status word
   localparam int          STATUS_PCWF_BIT  = 7;
   localparam int          STATUS_TO_BIT    = 4;
   localparam int          STATUS_PD_BIT    = 3;
   localparam int          STATUS_SLEEP_BIT = 0;

   // Watchdog timing, counted in watchdog oscillator ticks
   localparam int          WDT_PERIOD_MS    = 18;
   localparam int          WDT_OSC_KHZ      = 32;
   localparam int          WDT_TIMEOUT_TICKS = WDT_PERIOD_MS * WDT_OSC_KHZ;
   localparam int          WDT_CNT_W        = 10;
   localparam int          PRESCALE_W       = 7;
   localparam logic [WDT_CNT_W-1:0] WDT_CNT_TOP = WDT_CNT_W'(WDT_TIMEOUT_TICKS - 1);

   // AXI response codes
   localparam logic [1:0]  RESP_OKAY        = 2'h0;
   localparam logic [1:0]  RESP_SLVERR      = 2'h2;

   // Prescaler and option byte, bit 7 down to bit 0
   typedef struct packed {
      logic       pin_wake_enable_n;
      logic       pin_pullup_enable_n;
      logic       timer_clock_source;
      logic       timer_source_edge;
      logic       prescaler_assign;
      logic [2:0] prescale_rate;
   } option_t;

   // Reset-cause flags
   typedef struct packed {
      logic pin_change_wake_flag;
      logic timeout_flag_n;
      logic powerdown_flag_n;
   } reset_flags_t;

   localparam reset_flags_t FLAGS_POR = '{pin_change_wake_flag: 1'b0, timeout_flag_n: 1'b1,
                                          powerdown_flag_n: 1'b1};

   typedef enum logic {
      ST_AWAKE  = 1'b0,
      ST_ASLEEP = 1'b1
   } power_state_t;

endpackage

// >>> logic/watchdog_counter.sv
`timescale 1ns/10ps
module watchdog_counter
   import sleep_wake_pkg::*;
(
   input  wire logic       i_clk,
   input  wire logic       i_rst_n,
   input  wire logic       i_tick,
   input  wire logic       i_clear,
   input  wire logic       i_enable,
   input  wire logic       i_prescale_assign,
   input  wire logic [2:0] i_prescale_rate,
   output logic            o_timeout
);
   logic [WDT_CNT_W-1:0]  cnt_r;
   logic [PRESCALE_W-1:0] pre_r;
   logic [7:0]            ratio;
   logic [PRESCALE_W-1:0] pre_top;
   logic                  step;

   // Prescaler terminal count; ratio 1:1 when the prescaler serves the timer
   assign ratio   = 8'h01 << i_prescale_rate;
   assign pre_top = PRESCALE_W'(ratio - 8'h01);
   assign step    = i_tick && (!i_prescale_assign || pre_r == pre_top);

   // Clear wins over a tick so a cleared watchdog never fires late
   // fuse stops counting
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         cnt_r     <= '0;
         pre_r     <= '0;
         o_timeout <= 1'b0;
      end
      else
      begin
         o_timeout <= i_enable && !i_clear && step && cnt_r == WDT_CNT_TOP;
         if (i_clear || !i_enable)
         begin
            cnt_r <= '0;
            pre_r <= '0;
         end
         else if (i_tick)
         begin
            pre_r <= (step || !i_prescale_assign) ? '0 : pre_r + 1'b1;
            if (step)
               cnt_r <= (cnt_r == WDT_CNT_TOP) ? '0 : cnt_r + 1'b1;
         end
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   property p_clear_zeroes;
      i_clear |=> cnt_r == '0 && pre_r == '0 && !o_timeout;
   endproperty
   a_clear_zeroes: assert property (p_clear_zeroes) else $error("watchdog not zeroed by clear");

   property p_fuse_off;
      !i_enable [*2] |-> !o_timeout;
   endproperty
   a_fuse_off: assert property (p_fuse_off) else $error("timeout while watchdog disabled");

endmodule

// >>> logic/wake_change_detect.sv
`timescale 1ns/10ps
module wake_change_detect
(
   input  wire logic       i_clk,
   input  wire logic       i_rst_n,
   input  wire logic [2:0] i_pins,
   input  wire logic       i_latch,
   input  wire logic [2:0] i_mask,
   output logic            o_change
);
   logic [2:0] latched_r;
   logic [2:0] differs;

   // One latch and comparator per wake pin
   genvar g;
   generate
      for (g = 0; g < 3; g++)
      begin : g_pin
         always_ff @(posedge i_clk or negedge i_rst_n)
         begin
            if (!i_rst_n)
               latched_r[g] <= 1'b0;
            else if (i_latch)
               latched_r[g] <= i_pins[g];
         end
         assign differs[g] = i_mask[g] && (i_pins[g] != latched_r[g]);
      end
   endgenerate

   // Registered so the change reads as a clean level
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         o_change <= 1'b0;
      else
         o_change <= |differs;
   end

endmodule

// >>> logic/sleep_wake_reset_cause.sv
`timescale 1ns/10ps
module sleep_wake_reset_cause
   import sleep_wake_pkg::*;
(
   input  wire logic        I_CLOCK,
   input  wire logic        I_RST_N,
   input  wire logic [7:0]  I_AXI_AWADDR,
   input  wire logic        I_AXI_AWVALID,
   output logic             O_AXI_AWREADY,
   input  wire logic [31:0] I_AXI_WDATA,
   input  wire logic [3:0]  I_AXI_WSTRB,
   input  wire logic        I_AXI_WVALID,
   output logic             O_AXI_WREADY,
   output logic [1:0]       O_AXI_BRESP,
   output logic             O_AXI_BVALID,
   input  wire logic        I_AXI_BREADY,
   input  wire logic [7:0]  I_AXI_ARADDR,
   input  wire logic        I_AXI_ARVALID,
   output logic             O_AXI_ARREADY,
   output logic [31:0]      O_AXI_RDATA,
   output logic [1:0]       O_AXI_RRESP,
   output logic             O_AXI_RVALID,
   input  wire logic        I_AXI_RREADY,
   input  wire logic        I_CLEAR_WATCHDOG,
   input  wire logic        I_SLEEP_EXEC,
   input  wire logic        I_PORT_ACCESS,
   input  wire logic [2:0]  I_WAKE_PINS,
   input  wire logic        I_MASTER_CLEAR_PIN_N,
   input  wire logic        I_MASTER_CLEAR_ENABLE,
   input  wire logic        I_WATCHDOG_ENABLE_FUSE,
   input  wire logic        I_WATCHDOG_OSC,
   input  wire logic [3:0]  I_PIN_OUT,
   input  wire logic [3:0]  I_PIN_OE_N,
   output logic [3:0]       O_PIN_OUT,
   output logic [3:0]       O_PIN_OE_N,
   output logic             O_OSC_DRIVE_EN,
   output logic             O_DEVICE_RESET,
   output logic             O_ASLEEP
);
   import sleep_wake_pkg::*;

   power_state_t state_r;
   power_state_t state_nxt;
   option_t      option_r;
   reset_flags_t flags_r;
   reset_flags_t flags_nxt;
   logic         osc_s1_r;
   logic         osc_s2_r;
   logic         osc_s3_r;
   logic         wdt_tick;
   logic         wdt_timeout;
   logic         wdt_clear;
   logic         pin_change;
   logic [2:0]   wake_mask;
   logic         asleep;
   logic         clear_active;
   logic         clear_active_r;
   logic         clear_fall;
   logic         ev_clear_sleep;
   logic         ev_clear_awake;
   logic         ev_wdt_sleep;
   logic         ev_wdt_awake;
   logic         ev_pin;
   logic         reset_event;
   logic         sleep_go;
   logic         aw_held_r;
   logic         w_held_r;
   logic [7:0]   awaddr_r;
   logic [31:0]  wdata_r;
   logic         wstrb0_r;
   logic         aw_take;
   logic         w_take;
   logic         wr_do;
   logic         wr_option;
   logic         ar_take;
   logic         rd_hit;
   logic [31:0]  rd_word;

   // Watchdog oscillator: two-flop synchroniser, third flop for the edge
   // asynchronous tick synchronised
   always_ff @(posedge I_CLOCK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         osc_s1_r <= 1'b0;
         osc_s2_r <= 1'b0;
         osc_s3_r <= 1'b0;
      end
      else
      begin
         osc_s1_r <= I_WATCHDOG_OSC;
         osc_s2_r <= osc_s1_r;
         osc_s3_r <= osc_s2_r;
      end
   end
   assign wdt_tick = osc_s2_r && !osc_s3_r;

   // Watchdog cleared by instruction, sleep entry and every reset
   // clear on instruction
   assign wdt_clear = (I_CLEAR_WATCHDOG && !asleep) || sleep_go || reset_event || O_DEVICE_RESET;

   watchdog_counter u_watchdog (
      .i_clk             (I_CLOCK),
      .i_rst_n           (I_RST_N),
      .i_tick            (wdt_tick),
      .i_clear           (wdt_clear),
      .i_enable          (I_WATCHDOG_ENABLE_FUSE),
      .i_prescale_assign (option_r.prescaler_assign),
      .i_prescale_rate   (option_r.prescale_rate),
      .o_timeout         (wdt_timeout)
   );

   // Pin 3 doubles as the clear pin, so it cannot wake while serving that role
   // latch on port access
   assign wake_mask = option_r.pin_wake_enable_n ? 3'h0 : {!I_MASTER_CLEAR_ENABLE, 2'h3};

   wake_change_detect u_wake (
      .i_clk    (I_CLOCK),
      .i_rst_n  (I_RST_N),
      .i_pins   (I_WAKE_PINS),
      .i_latch  (I_PORT_ACCESS),
      .i_mask   (wake_mask),
      .o_change (pin_change)
   );

   // Reset sources in priority order: clear pin, watchdog, pin change
   // sleep exits
   assign asleep         = state_r == ST_ASLEEP;
   assign clear_active   = I_MASTER_CLEAR_ENABLE && !I_MASTER_CLEAR_PIN_N;
   assign clear_fall     = clear_active && !clear_active_r;
   assign ev_clear_sleep = clear_fall && asleep;
   assign ev_clear_awake = clear_fall && !asleep;
   assign ev_wdt_sleep   = wdt_timeout && asleep && !clear_active;
   assign ev_wdt_awake   = wdt_timeout && !asleep && !clear_active;
   assign ev_pin         = pin_change && asleep && !clear_active && !wdt_timeout;
   assign reset_event    = ev_clear_sleep || ev_clear_awake || ev_wdt_sleep || ev_wdt_awake || ev_pin;
   assign sleep_go       = I_SLEEP_EXEC && !asleep && !O_DEVICE_RESET && !clear_active && !reset_event;

   // Power state: sleeping stops on any reset event
   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         ST_AWAKE:
            if (sleep_go)
               state_nxt = ST_ASLEEP;
         ST_ASLEEP:
            if (reset_event)
               state_nxt = ST_AWAKE;
      endcase
   end

   // Reset-cause flags; unchanged unless a reset or sleep entry occurs
   // cause encoding
   always_comb
   begin
      flags_nxt = flags_r;
      if (ev_clear_sleep)
         flags_nxt = '{pin_change_wake_flag: 1'b0, timeout_flag_n: 1'b1, powerdown_flag_n: 1'b0};
      else if (ev_clear_awake)
         flags_nxt.pin_change_wake_flag = 1'b0;
      else if (ev_wdt_sleep)
         flags_nxt = '{pin_change_wake_flag: 1'b0, timeout_flag_n: 1'b0, powerdown_flag_n: 1'b0};
      else if (ev_wdt_awake)
      begin
         flags_nxt.pin_change_wake_flag = 1'b0;
         flags_nxt.timeout_flag_n       = 1'b0;
      end
      else if (ev_pin)
         flags_nxt = '{pin_change_wake_flag: 1'b1, timeout_flag_n: 1'b1, powerdown_flag_n: 1'b0};
      else if (sleep_go)
      begin
         flags_nxt.timeout_flag_n   = 1'b1;
         flags_nxt.powerdown_flag_n = 1'b0;
      end
   end

   // Flags move on the same edge that raises the device reset
   // power-up values
   always_ff @(posedge I_CLOCK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         state_r        <= ST_AWAKE;
         flags_r        <= FLAGS_POR;
         clear_active_r <= 1'b0;
         O_DEVICE_RESET <= 1'b1;
      end
      else
      begin
         state_r        <= state_nxt;
         flags_r        <= flags_nxt;
         clear_active_r <= clear_active;
         O_DEVICE_RESET <= reset_event || clear_active;
      end
   end

   // Pins follow the core while awake and freeze at sleep entry
   // hold pin state
   always_ff @(posedge I_CLOCK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         O_PIN_OUT  <= 4'h0;
         O_PIN_OE_N <= 4'hf;
      end
      else if (!asleep)
      begin
         O_PIN_OUT  <= I_PIN_OUT;
         O_PIN_OE_N <= I_PIN_OE_N;
      end
   end

   assign O_OSC_DRIVE_EN = !asleep;
   assign O_ASLEEP       = asleep;

   // AXI write: address and data taken in either order, one write at a time
   assign O_AXI_AWREADY = !aw_held_r && !O_AXI_BVALID;
   assign O_AXI_WREADY  = !w_held_r && !O_AXI_BVALID;
   assign aw_take       = I_AXI_AWVALID && O_AXI_AWREADY;
   assign w_take        = I_AXI_WVALID && O_AXI_WREADY;
   assign wr_do         = aw_held_r && w_held_r;
   assign wr_option     = wr_do && awaddr_r == OPTION_ADDR && wstrb0_r;

   always_ff @(posedge I_CLOCK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         aw_held_r    <= 1'b0;
         w_held_r     <= 1'b0;
         awaddr_r     <= 8'h00;
         wdata_r      <= 32'h0000_0000;
         wstrb0_r     <= 1'b0;
         O_AXI_BVALID <= 1'b0;
         O_AXI_BRESP  <= RESP_OKAY;
      end
      else
      begin
         if (aw_take)
            awaddr_r <= I_AXI_AWADDR;
         if (w_take)
         begin
            wdata_r  <= I_AXI_WDATA;
            wstrb0_r <= I_AXI_WSTRB[0];
         end
         aw_held_r <= (aw_held_r || aw_take) && !wr_do;
         w_held_r  <= (w_held_r || w_take) && !wr_do;
         if (wr_do)
         begin
            O_AXI_BVALID <= 1'b1;
            O_AXI_BRESP  <= (awaddr_r == OPTION_ADDR || awaddr_r == STATUS_ADDR) ? RESP_OKAY : RESP_SLVERR;
         end
         else if (I_AXI_BREADY)
            O_AXI_BVALID <= 1'b0;
      end
   end

   // Option byte returns to all ones on every device reset
   always_ff @(posedge I_CLOCK or negedge I_RST_N)
   begin
      if (!I_RST_N)
         option_r <= option_t'(OPTION_RESET);
      else if (O_DEVICE_RESET)
         option_r <= option_t'(OPTION_RESET);
      else if (wr_option)
         option_r <= option_t'(wdata_r[7:0]);
   end

   // AXI read: one cycle answer, unmapped addresses give SLVERR
   assign O_AXI_ARREADY = !O_AXI_RVALID;
   assign ar_take       = I_AXI_ARVALID && O_AXI_ARREADY;
   assign rd_hit        = I_AXI_ARADDR == OPTION_ADDR || I_AXI_ARADDR == STATUS_ADDR;
   always_comb
   begin
      rd_word = 32'h0000_0000;
      if (I_AXI_ARADDR == OPTION_ADDR)
         rd_word[7:0] = option_r;
      else if (I_AXI_ARADDR == STATUS_ADDR)
      begin
         rd_word[STATUS_PCWF_BIT]  = flags_r.pin_change_wake_flag;
         rd_word[STATUS_TO_BIT]    = flags_r.timeout_flag_n;
         rd_word[STATUS_PD_BIT]    = flags_r.powerdown_flag_n;
         rd_word[STATUS_SLEEP_BIT] = asleep;
      end
   end

   always_ff @(posedge I_CLOCK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         O_AXI_RVALID <= 1'b0;
         O_AXI_RDATA  <= 32'h0000_0000;
         O_AXI_RRESP  <= RESP_OKAY;
      end
      else if (ar_take)
      begin
         O_AXI_RVALID <= 1'b1;
         O_AXI_RDATA  <= rd_word;
         O_AXI_RRESP  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (I_AXI_RREADY)
         O_AXI_RVALID <= 1'b0;
   end

   default clocking cb @(posedge I_CLOCK); endclocking
   default disable iff (!I_RST_N);

   sequence s_reset_seen;
      O_DEVICE_RESET;
   endsequence

   property p_sleep_entry;
      sleep_go |=> asleep && !O_OSC_DRIVE_EN && flags_r.timeout_flag_n && !flags_r.powerdown_flag_n;
   endproperty
   a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry state wrong");

   property p_pins_held;
      asleep && $past(asleep) |-> $stable(O_PIN_OUT) && $stable(O_PIN_OE_N);
   endproperty
   a_pins_held: assert property (p_pins_held) else $error("pins moved during sleep");

   property p_wdt_wake;
      ev_wdt_sleep |=> s_reset_seen and !asleep and flags_r == 3'b000;
   endproperty
   a_wdt_wake: assert property (p_wdt_wake) else $error("watchdog wake flags wrong");

   property p_wdt_awake;
      ev_wdt_awake |=> s_reset_seen and !flags_r.timeout_flag_n and !flags_r.pin_change_wake_flag
                       and flags_r.powerdown_flag_n == $past(flags_r.powerdown_flag_n);
   endproperty
   a_wdt_awake: assert property (p_wdt_awake) else $error("awake watchdog flags wrong");

   property p_clear_wake;
      ev_clear_sleep |=> s_reset_seen and flags_r == 3'b010;
   endproperty
   a_clear_wake: assert property (p_clear_wake) else $error("clear pin wake flags wrong");

   property p_pin_wake;
      ev_pin |=> s_reset_seen and !asleep and flags_r == 3'b110;
   endproperty
   a_pin_wake: assert property (p_pin_wake) else $error("pin change wake flags wrong");

   property p_flags_hold;
      !reset_event && !sleep_go |=> $stable(flags_r);
   endproperty
   a_flags_hold: assert property (p_flags_hold) else $error("flags changed without cause");

   property p_sleep_exit;
      asleep && clear_active ##1 clear_active |-> !asleep;
   endproperty
   a_sleep_exit: assert property (p_sleep_exit) else $error("clear pin did not end sleep");

endmodule

// >>> test/wake_pins_model.sv
`timescale 1ns/10ps
module wake_pins_model
(
   input  wire logic       i_clear_low,
   input  wire logic [2:0] i_levels,
   output logic            o_clear_pin_n,
   output logic [2:0]      o_wake_pins,
   output logic            o_osc
);
   // Watchdog oscillator runs free, in sleep too, unrelated in phase
   initial o_osc = 1'b0;
   always #5.5 o_osc = ~o_osc;
   // Clear pin has a pull-up, so it idles high unless pulled low
   assign o_clear_pin_n = ~i_clear_low;
   // Wake pins are plain board levels
   assign o_wake_pins = i_levels;
endmodule

// >>> test/tb_sleep_wake_reset_cause.sv
`timescale 1ns/10ps
module tb_sleep_wake_reset_cause;
   import sleep_wake_pkg::*;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  awaddr = 8'h00;
   logic [7:0]  araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        clr_wd = 1'b0, sleep_ex = 1'b0, port_acc = 1'b0, clear_low = 1'b0, fuse = 1'b1, master_clear_pin_en = 1'b1;
   logic [2:0]  levels = 3'h0;
   logic [3:0]  pin_out = 4'h0, pin_oe_n = 4'hf;
   logic        awready, wready, bvalid, arready, rvalid, clear_n, osc, osc_en, dev_rst, asleep;
   logic [1:0]  bresp, rresp, resp;
   logic [31:0] rdata, data;
   logic [2:0]  pins;
   logic [3:0]  pin_o, pin_oe_o;
   int          n_errors = 0, total_checks = 0, cycles = 0, n_rst = 0, lat, k;

   wake_pins_model partner (.i_clear_low(clear_low), .i_levels(levels), .o_clear_pin_n(clear_n),
      .o_wake_pins(pins), .o_osc(osc));

   sleep_wake_reset_cause dut (.I_CLOCK(clk), .I_RST_N(rst_n), .I_AXI_AWADDR(awaddr),
      .I_AXI_AWVALID(awvalid), .O_AXI_AWREADY(awready), .I_AXI_WDATA(wdata), .I_AXI_WSTRB(4'hf),
      .I_AXI_WVALID(wvalid), .O_AXI_WREADY(wready), .O_AXI_BRESP(bresp), .O_AXI_BVALID(bvalid),
      .I_AXI_BREADY(bready), .I_AXI_ARADDR(araddr), .I_AXI_ARVALID(arvalid), .O_AXI_ARREADY(arready),
      .O_AXI_RDATA(rdata), .O_AXI_RRESP(rresp), .O_AXI_RVALID(rvalid), .I_AXI_RREADY(rready),
      .I_CLEAR_WATCHDOG(clr_wd), .I_SLEEP_EXEC(sleep_ex), .I_PORT_ACCESS(port_acc), .I_WAKE_PINS(pins),
      .I_MASTER_CLEAR_PIN_N(clear_n), .I_MASTER_CLEAR_ENABLE(master_clear_pin_en), .I_WATCHDOG_ENABLE_FUSE(fuse),
      .I_WATCHDOG_OSC(osc), .I_PIN_OUT(pin_out), .I_PIN_OE_N(pin_oe_n), .O_PIN_OUT(pin_o),
      .O_PIN_OE_N(pin_oe_o), .O_OSC_DRIVE_EN(osc_en), .O_DEVICE_RESET(dev_rst), .O_ASLEEP(asleep));

   // Clock and reset-event count
   always #2 clk = ~clk;
   always @(posedge dev_rst) n_rst++;

   // Hang guard, well above the expected length of the run
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         n_errors++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e)
      begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Handshakes judged mid-cycle, so inputs only move right after an edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw, w, b;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      b = 1'b0;
      while (!b)
      begin
         @(negedge clk);
         aw = awvalid && awready;
         w = wvalid && wready;
         b = bvalid;
         r = bresp;
         @(posedge clk);
         if (aw) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
      end
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ar, v;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      v = 1'b0;
      while (!v)
      begin
         @(negedge clk);
         ar = arvalid && arready;
         v = rvalid;
         d = rdata;
         r = rresp;
         @(posedge clk);
         if (ar) arvalid <= 1'b0;
      end
      rready <= 1'b0;
   endtask

   task automatic st(input logic [31:0] e);
      rd(STATUS_ADDR, data, resp);
      chk("status", e, data);
   endtask

   // Wait up to mx cycles for a device reset pulse to come, then without bound for it to go
   task automatic wait_rst(input int mx, output int n);
      n = 0;
      while (dev_rst !== 1'b1 && n < mx)
      begin
         @(negedge clk);
         n++;
      end
      while (dev_rst === 1'b1) @(negedge clk);
   endtask

   // Read the port right before sleeping, so no stale latch wakes us
   // latch then sleep
   task automatic snooze();
      @(posedge clk);
      port_acc <= 1'b1;
      @(posedge clk);
      port_acc <= 1'b0;
      sleep_ex <= 1'b1;
      @(posedge clk);
      sleep_ex <= 1'b0;
      repeat (2) @(posedge clk);
   endtask

   task automatic master_clear_pin();
      @(posedge clk);
      clear_low <= 1'b1;
      repeat (3) @(posedge clk);
      clear_low <= 1'b0;
      wait_rst(20, lat);
   endtask

   // Main sequence
   initial
   begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      st(32'h0000_0018);
      rd(OPTION_ADDR, data, resp);
      chk("option", {24'h00_0000, OPTION_RESET}, data);
      rd(8'h08, data, resp);
      chk("rresp", {30'h0, RESP_SLVERR}, {30'h0, resp});
      chk("rdata", 32'h0000_0000, data);
      wr(8'h08, 32'h0000_0000, resp);
      chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, resp});
      wr(STATUS_ADDR, 32'h0000_0000, resp);
      st(32'h0000_0018);
      // Pin wake on, prescaler off the watchdog for a short period
      wr(OPTION_ADDR, 32'h0000_0000, resp);
      rd(OPTION_ADDR, data, resp);
      chk("option", 32'h0000_0000, data);
      k = n_rst;
      repeat (4)
      begin
         repeat (1000) @(posedge clk);
         clr_wd <= 1'b1;
         @(posedge clk);
         clr_wd <= 1'b0;
      end
      chk("resets", k, n_rst);
      wait_rst(3000, lat);
      chk("wd_fired", 1, lat < 3000);
      st(32'h0000_0008);
      @(posedge clk);
      pin_out <= 4'h5;
      pin_oe_n <= 4'h0;
      snooze();
      chk("asleep", 1, asleep);
      chk("osc_en", 0, osc_en);
      st(32'h0000_0011);
      @(posedge clk);
      pin_out <= 4'ha;
      pin_oe_n <= 4'hf;
      repeat (3) @(posedge clk);
      chk("pin_out", 4'h5, pin_o);
      chk("pin_oe_n", 4'h0, pin_oe_o);
      master_clear_pin();
      st(32'h0000_0010);
      chk("asleep", 0, asleep);
      // Every reset puts the option byte back to all ones, so pin wake is off again
      wr(OPTION_ADDR, 32'h0000_0000, resp);
      snooze();
      @(posedge clk);
      levels <= 3'b001;
      wait_rst(20, lat);
      chk("pin_wake", 1, lat < 20);
      st(32'h0000_0090);
      master_clear_pin();
      st(32'h0000_0010);
      // Prescaler off the watchdog, pin wake off; counter part way up before sleep
      wr(OPTION_ADDR, 32'h0000_0080, resp);
      repeat (1000) @(posedge clk);
      snooze();
      wait_rst(3000, lat);
      chk("sleep_span", 1, lat >= 1500 && lat < 3000);
      st(32'h0000_0000);
      // Clear pin as plain input: a low pulse is ignored, a pin 3 change wakes
      @(posedge clk);
      master_clear_pin_en <= 1'b0;
      wr(OPTION_ADDR, 32'h0000_0000, resp);
      snooze();
      k = n_rst;
      @(posedge clk);
      clear_low <= 1'b1;
      repeat (3) @(posedge clk);
      clear_low <= 1'b0;
      repeat (3) @(posedge clk);
      chk("resets", k, n_rst);
      chk("asleep", 1, asleep);
      levels <= 3'b101;
      wait_rst(20, lat);
      chk("pin3_wake", 1, lat < 20);
      st(32'h0000_0090);
      @(posedge clk);
      master_clear_pin_en <= 1'b1;
      // Short unscaled period, so an enabled watchdog would fire inside the wait
      wr(OPTION_ADDR, 32'h0000_0080, resp);
      @(posedge clk);
      fuse <= 1'b0;
      snooze();
      k = n_rst;
      repeat (2500) @(posedge clk);
      chk("asleep", 1, asleep);
      chk("resets", k, n_rst);
      master_clear_pin();
      @(posedge clk);
      fuse <= 1'b1;
      tally_and_finish();
   end
endmodule
